// File: mbe_exec.sv
// Execution of branch, skip, table, misc and add/AND operations.
// Assumes data memory read data matches instr_addr in the same cycle,
// program memory answers while prog_rd_en stands, and the stack
// presents its top word combinationally.
`timescale 1ns/10ps
`include "mbe_defines.svh"

module mbe_exec
#(
  parameter int PC_W = 11
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction in
  input wire logic instr_valid,
  input wire mbe_pkg::mbe_op_type instr_op,
  input wire logic [7:0] instr_addr,
  input wire logic [7:0] instr_imm,
  input wire logic [2:0] instr_bit,
  input wire logic [PC_W-1:0] instr_target,
  output logic instr_ready,
  // Program counter
  output logic [PC_W-1:0] pc,
  // Data memory
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_en,
  output logic [7:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  // Table fetch
  input wire logic [7:0] tbl_ptr,
  output logic prog_rd_en,
  output logic [PC_W-1:0] prog_rd_addr,
  input wire logic [`MBE_PROG_W-1:0] prog_rd_data,
  output logic [7:0] table_high_latch,
  // Stack
  input wire logic [PC_W-1:0] stack_top,
  output logic stack_push,
  output logic [PC_W-1:0] stack_push_data,
  output logic stack_pop,
  output logic interrupt_exit_pulse,
  // Core state
  output logic [7:0] acc,
  output logic flag_c,
  output logic flag_ac,
  output logic flag_z,
  output logic flag_ov,
  // Watchdog and power
  input wire logic timeout_evt,
  input wire logic wake,
  output logic powerdown_mode,
  output logic watchdog_expiry_flag,
  output logic powerdown_flag,
  output logic watchdog_restart
);
  import mbe_pkg::*;

  // Refuse widths the page logic cannot serve
  if (PC_W < 9 || PC_W > 16)
  begin : g_pc_w_check
    $error("PC_W must lie between 9 and 16");
  end

  mbe_state_type state_reg;
  logic skip_reg;
  logic take;
  logic exec;
  logic [7:0] m_val;
  logic [7:0] m_inc;
  logic [7:0] m_dec;
  logic [7:0] alu_b;
  logic alu_cin;
  logic alu_and;
  logic [7:0] alu_res;
  logic alu_ov;
  logic alu_z;
  logic alu_ac;
  logic alu_c;
  logic acc_we;
  logic [7:0] acc_data;
  logic mem_we;
  logic [7:0] mem_data;
  logic arith_we;
  logic zero_we;
  logic skip_cond;
  logic two_cycle;
  logic table_op;
  logic pcl_hit;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] pc_plus1;
  logic [7:0] tbl_dst_reg;

  // ==========================================================
  // Operand fetch
  // Handshake and issue
  assign instr_ready = (state_reg == ST_RUN) && !powerdown_mode;
  assign take = instr_valid && instr_ready;
  assign exec = take && !skip_reg;
  assign pc_plus1 = pc + 1'b1;
  // Forward a write still in flight to the memory
  assign m_val = (mem_wr_en && mem_wr_addr == instr_addr) ?
                 mem_wr_data : mem_rd_data;
  assign m_inc = m_val + 8'h01;
  assign m_dec = m_val - 8'h01;

  mbe_alu u_alu
  (
    .a(acc),
    .b(alu_b),
    .cin(alu_cin),
    .do_and(alu_and),
    .res(alu_res),
    .ov(alu_ov),
    .z(alu_z),
    .ac(alu_ac),
    .c(alu_c)
  );

  // ==========================================================
  // Decode
  always_comb
  begin
    alu_b = m_val;
    alu_cin = 1'b0;
    alu_and = 1'b0;
    acc_we = 1'b0;
    acc_data = alu_res;
    mem_we = 1'b0;
    mem_data = alu_res;
    arith_we = 1'b0;
    zero_we = 1'b0;
    skip_cond = 1'b0;
    two_cycle = 1'b0;
    table_op = 1'b0;
    pc_next = pc_plus1;
    case (instr_op)
      OP_SUM_CARRY:
      begin
        alu_cin = flag_c;
        acc_we = 1'b1;
        arith_we = 1'b1;
      end
      OP_SUM_CARRY_TO_MEMORY:
      begin
        alu_cin = flag_c;
        mem_we = 1'b1;
        arith_we = 1'b1;
      end
      OP_SUM_MEM:
      begin
        acc_we = 1'b1;
        arith_we = 1'b1;
      end
      OP_SUM_IMM:
      begin
        alu_b = instr_imm;
        acc_we = 1'b1;
        arith_we = 1'b1;
      end
      OP_SUM_TO_MEMORY:
      begin
        mem_we = 1'b1;
        arith_we = 1'b1;
      end
      OP_CONJ_MEM:
      begin
        alu_and = 1'b1;
        acc_we = 1'b1;
        zero_we = 1'b1;
      end
      OP_CONJ_IMM:
      begin
        alu_b = instr_imm;
        alu_and = 1'b1;
        acc_we = 1'b1;
        zero_we = 1'b1;
      end
      OP_BITWISE_CONJ_TO_MEMORY:
      begin
        alu_and = 1'b1;
        mem_we = 1'b1;
        zero_we = 1'b1;
      end
      OP_MEM_CLEAR:
      begin
        mem_we = 1'b1;
        mem_data = `MBE_BYTE_ZERO;
      end
      OP_MEM_SET:
      begin
        mem_we = 1'b1;
        mem_data = `MBE_BYTE_ONES;
      end
      OP_NIBBLE_EXCHANGE:
      begin
        mem_we = 1'b1;
        mem_data = {m_val[3:0], m_val[7:4]};
      end
      OP_NIBBLE_EXCHANGE_TO_WORKING:
      begin
        acc_we = 1'b1;
        acc_data = {m_val[3:0], m_val[7:4]};
      end
      OP_UNCONDITIONAL_BRANCH, OP_SUB_CALL:
      begin
        two_cycle = 1'b1;
        pc_next = instr_target;
      end
      OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT:
      begin
        two_cycle = 1'b1;
        pc_next = stack_top;
      end
      OP_SUBROUTINE_EXIT_LOAD:
      begin
        two_cycle = 1'b1;
        pc_next = stack_top;
        acc_we = 1'b1;
        acc_data = instr_imm;
      end
      OP_SKIP_ON_ZERO_MEMORY:
        skip_cond = (m_val == 8'h00);
      OP_SKIP_ZERO_LOAD_WORKING:
      begin
        skip_cond = (m_val == 8'h00);
        acc_we = 1'b1;
        acc_data = m_val;
      end
      OP_SKIP_BIT_CLEAR:
        skip_cond = !m_val[instr_bit];
      OP_SKIP_BIT_SET:
        skip_cond = m_val[instr_bit];
      OP_INCREMENT_SKIP_ZERO:
      begin
        mem_we = 1'b1;
        mem_data = m_inc;
        skip_cond = (m_inc == 8'h00);
      end
      OP_DECREMENT_SKIP_ZERO:
      begin
        mem_we = 1'b1;
        mem_data = m_dec;
        skip_cond = (m_dec == 8'h00);
      end
      OP_DECREMENT_SKIP_ZERO_LOAD:
      begin
        acc_we = 1'b1;
        acc_data = m_dec;
        skip_cond = (m_dec == 8'h00);
      end
      OP_TABLE_FETCH, OP_TABLE_FETCH_LAST_PAGE:
        table_op = 1'b1;
      default:
        pc_next = pc_plus1;
    endcase
    // low byte write costs a cycle
    if (mem_we && instr_addr == `MBE_PCL_ADDR)
    begin
      two_cycle = 1'b1;
      pc_next = {pc[PC_W-1:8], mem_data};
    end
  end
  assign pcl_hit = mem_we && instr_addr == `MBE_PCL_ADDR;

  // ==========================================================
  // Sequencer, program counter and skip
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= ST_RUN;
      skip_reg <= 1'b0;
      pc <= '0;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          if (take && skip_reg)
          begin
            skip_reg <= 1'b0;
            pc <= pc_plus1;
          end
          else if (take)
          begin
            skip_reg <= skip_cond;
            pc <= pc_next;
            if (table_op)
              state_reg <= ST_TABLE;
            else if (two_cycle)
              state_reg <= ST_SECOND;
          end
        end
        ST_SECOND:
          state_reg <= ST_RUN;
        ST_TABLE:
          state_reg <= ST_RUN;
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge clk)
  begin
    if (srst)
      acc <= `MBE_ACC_RST;
    else if (exec && acc_we)
      acc <= acc_data;
  end

  // Arithmetic flags
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flag_c <= 1'b0;
      flag_ac <= 1'b0;
      flag_z <= 1'b0;
      flag_ov <= 1'b0;
    end
    else if (exec && arith_we)
    begin
      flag_c <= alu_c;
      flag_ac <= alu_ac;
      flag_z <= alu_z;
      flag_ov <= alu_ov;
    end
    else if (exec && zero_we)
      flag_z <= alu_z;
  end

  // Data memory writes, table low byte in its second cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mem_wr_en <= 1'b0;
      mem_wr_addr <= 8'h00;
      mem_wr_data <= 8'h00;
    end
    else if (state_reg == ST_TABLE)
    begin
      mem_wr_en <= 1'b1;
      mem_wr_addr <= tbl_dst_reg;
      mem_wr_data <= prog_rd_data[`MBE_PROG_LO_MSB:0];
    end
    else
    begin
      mem_wr_en <= exec && mem_we;
      mem_wr_addr <= instr_addr;
      mem_wr_data <= mem_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prog_rd_en <= 1'b0;
      prog_rd_addr <= '0;
      tbl_dst_reg <= 8'h00;
      table_high_latch <= 8'h00;
    end
    else
    begin
      prog_rd_en <= exec && table_op;
      if (exec && table_op)
      begin
        tbl_dst_reg <= instr_addr;
        if (instr_op == OP_TABLE_FETCH_LAST_PAGE)
          prog_rd_addr <= {{(PC_W-8){1'b1}}, tbl_ptr};
        else
          prog_rd_addr <= {pc[PC_W-1:8], tbl_ptr};
      end
      if (state_reg == ST_TABLE)
        table_high_latch <=
          prog_rd_data[`MBE_PROG_HI_MSB:`MBE_PROG_HI_LSB];
    end
  end

  // Stack traffic
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stack_push <= 1'b0;
      stack_push_data <= '0;
      stack_pop <= 1'b0;
      interrupt_exit_pulse <= 1'b0;
    end
    else
    begin
      stack_push <= exec && instr_op == OP_SUB_CALL;
      stack_push_data <= pc_plus1;
      stack_pop <= exec && (instr_op == OP_SUBROUTINE_EXIT ||
                   instr_op == OP_SUBROUTINE_EXIT_LOAD ||
                   instr_op == OP_INTERRUPT_EXIT);
      interrupt_exit_pulse <= exec && instr_op == OP_INTERRUPT_EXIT;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      powerdown_mode <= 1'b0;
    else if (exec && instr_op == OP_POWER_DOWN)
      powerdown_mode <= 1'b1;
    else if (wake)
      powerdown_mode <= 1'b0;
  end

  mbe_wdt u_wdt
  (
    .clk(clk),
    .srst(srst),
    .step(take),
    .pre_first(!skip_reg && instr_op == OP_WATCHDOG_PRECLEAR_FIRST),
    .pre_second(!skip_reg && instr_op == OP_WATCHDOG_PRECLEAR_SECOND),
    .clear_cmd(!skip_reg && instr_op == OP_WATCHDOG_CLEAR),
    .halt_cmd(!skip_reg && instr_op == OP_POWER_DOWN),
    .timeout_evt(timeout_evt),
    .watchdog_expiry_flag(watchdog_expiry_flag),
    .powerdown_flag(powerdown_flag),
    .watchdog_restart(watchdog_restart)
  );

  // ==========================================================
  // Checks
  property p_skip_discard;
    @(posedge clk) disable iff (srst)
    (exec && skip_cond) ##1 take |=> !mem_wr_en && $stable(acc);
  endproperty
  a_skip_discard: assert property (p_skip_discard)
    else $error("skipped slot had an effect");

  property p_pcl_two;
    @(posedge clk) disable iff (srst)
    (exec && pcl_hit) |=> !instr_ready ##1 instr_ready;
  endproperty
  a_pcl_two: assert property (p_pcl_two)
    else $error("low byte write not two cycles");

  property p_branch;
    @(posedge clk) disable iff (srst)
    (exec && instr_op == OP_UNCONDITIONAL_BRANCH)
      |=> pc == $past(instr_target) && !instr_ready && $stable(flag_c);
  endproperty
  a_branch: assert property (p_branch)
    else $error("jump target or timing wrong");

  property p_call;
    @(posedge clk) disable iff (srst)
    (exec && instr_op == OP_SUB_CALL)
      |=> stack_push && stack_push_data == $past(pc) + 1'b1;
  endproperty
  a_call: assert property (p_call)
    else $error("call pushed wrong address");

  property p_table;
    @(posedge clk) disable iff (srst)
    (exec && table_op) |=> prog_rd_en && !instr_ready ##1
      mem_wr_en && table_high_latch == $past(prog_rd_data[15:8]) &&
      mem_wr_data == $past(prog_rd_data[7:0]);
  endproperty
  a_table: assert property (p_table)
    else $error("table fetch result wrong");

  property p_conj_flags;
    @(posedge clk) disable iff (srst)
    (exec && instr_op == OP_CONJ_IMM)
      |=> $stable(flag_c) && $stable(flag_ov) && acc == $past(acc & instr_imm);
  endproperty
  a_conj_flags: assert property (p_conj_flags)
    else $error("AND result or flags wrong");

  property p_dec_load;
    @(posedge clk) disable iff (srst)
    (exec && instr_op == OP_DECREMENT_SKIP_ZERO_LOAD)
      |=> acc == $past(m_dec) && !mem_wr_en && skip_reg == (acc == 8'h00);
  endproperty
  a_dec_load: assert property (p_dec_load)
    else $error("decrement load form wrong");

  property p_halt;
    @(posedge clk) disable iff (srst)
    (exec && instr_op == OP_POWER_DOWN) |=> powerdown_mode && powerdown_flag;
  endproperty
  a_halt: assert property (p_halt)
    else $error("power-down not entered");

  c_skip: cover property (@(posedge clk) disable iff (srst)
    (exec && skip_cond) ##1 take);
  c_table: cover property (@(posedge clk) disable iff (srst)
    exec && instr_op == OP_TABLE_FETCH_LAST_PAGE);
  c_carry: cover property (@(posedge clk) disable iff (srst)
    exec && instr_op == OP_SUM_CARRY && flag_c && alu_c);

endmodule // mbe_exec

// File: mbe_defines.svh
// Shared constants of the branch, misc and arithmetic execution block.
// Assumes one core instruction clock and 8-bit data memory words.
`ifndef MBE_DEFINES_SVH
`define MBE_DEFINES_SVH

// Data memory address of the program counter low byte
`define MBE_PCL_ADDR 8'h02
// Accumulator reset value and the clear/set fill bytes
`define MBE_ACC_RST 8'h00
`define MBE_BYTE_ZERO 8'h00
`define MBE_BYTE_ONES 8'hFF
// Program word layout for table fetches
`define MBE_PROG_W 16
`define MBE_PROG_HI_MSB 15
`define MBE_PROG_HI_LSB 8
`define MBE_PROG_LO_MSB 7

`endif

// File: mbe_pkg.sv
// Types of the branch, misc and arithmetic execution block.
// Assumes the fetch logic presents one decoded operation at a time.
package mbe_pkg;

  // ==========================================================
  // Decoded operations
  typedef enum logic [4:0] {
    OP_NO_OPERATION = 5'h00,
    OP_MEM_CLEAR = 5'h01,
    OP_MEM_SET = 5'h02,
    OP_NIBBLE_EXCHANGE = 5'h03,
    OP_NIBBLE_EXCHANGE_TO_WORKING = 5'h04,
    OP_SUM_CARRY = 5'h05,
    OP_SUM_CARRY_TO_MEMORY = 5'h06,
    OP_SUM_MEM = 5'h07,
    OP_SUM_IMM = 5'h08,
    OP_SUM_TO_MEMORY = 5'h09,
    OP_CONJ_MEM = 5'h0A,
    OP_CONJ_IMM = 5'h0B,
    OP_BITWISE_CONJ_TO_MEMORY = 5'h0C,
    OP_UNCONDITIONAL_BRANCH = 5'h0D,
    OP_SUB_CALL = 5'h0E,
    OP_SUBROUTINE_EXIT = 5'h0F,
    OP_SUBROUTINE_EXIT_LOAD = 5'h10,
    OP_INTERRUPT_EXIT = 5'h11,
    OP_SKIP_ON_ZERO_MEMORY = 5'h12,
    OP_SKIP_ZERO_LOAD_WORKING = 5'h13,
    OP_SKIP_BIT_CLEAR = 5'h14,
    OP_SKIP_BIT_SET = 5'h15,
    OP_INCREMENT_SKIP_ZERO = 5'h16,
    OP_DECREMENT_SKIP_ZERO = 5'h17,
    OP_DECREMENT_SKIP_ZERO_LOAD = 5'h18,
    OP_TABLE_FETCH = 5'h19,
    OP_TABLE_FETCH_LAST_PAGE = 5'h1A,
    OP_POWER_DOWN = 5'h1B,
    OP_WATCHDOG_CLEAR = 5'h1C,
    OP_WATCHDOG_PRECLEAR_FIRST = 5'h1D,
    OP_WATCHDOG_PRECLEAR_SECOND = 5'h1E
  } mbe_op_type;

  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SECOND = 3'b010,
    ST_TABLE = 3'b100
  } mbe_state_type;

  // Watchdog pre-clear history
  typedef enum logic [1:0] {
    PRE_NONE = 2'h0,
    PRE_FIRST = 2'h1,
    PRE_SECOND = 2'h2
  } mbe_pre_type;

endpackage

// File: mbe_alu.sv
// Eight-bit adder and AND unit with overflow, zero, half and full carry.
// Assumes purely combinational use; the caller registers the results.
`timescale 1ns/10ps

module mbe_alu
(
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic do_and,
  // Results
  output logic [7:0] res,
  output logic ov,
  output logic z,
  output logic ac,
  output logic c
);

  logic [8:0] sum9;
  logic [4:0] low5;

  // ==========================================================
  // Sum and flag terms
  assign sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign low5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};

  // Result select and flags
  always_comb
  begin
    if (do_and)
    begin
      res = a & b;
      ov = 1'b0;
      ac = 1'b0;
      c = 1'b0;
    end
    else
    begin
      res = sum9[7:0];
      ov = (a[7] == b[7]) && (sum9[7] != a[7]);
      ac = low5[4];
      c = sum9[8];
    end
    z = (res == 8'h00);
  end

endmodule // mbe_alu

// File: mbe_wdt.sv
// Timeout and power-down flags with the watchdog clear sequences.
// Assumes one step pulse per instruction slot from the sequencer.
`timescale 1ns/10ps

module mbe_wdt
  import mbe_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction slot and commands
  input wire logic step,
  input wire logic pre_first,
  input wire logic pre_second,
  input wire logic clear_cmd,
  input wire logic halt_cmd,
  // Watchdog event
  input wire logic timeout_evt,
  // Flags and restart
  output logic watchdog_expiry_flag,
  output logic powerdown_flag,
  output logic watchdog_restart
);

  mbe_pre_type last_reg;
  logic pair_done;
  logic flag_clear;

  // ==========================================================
  // Pre-clear pairing
  // alternating pair completes
  assign pair_done = step && ((pre_first && last_reg == PRE_SECOND) ||
                     (pre_second && last_reg == PRE_FIRST));
  assign flag_clear = step && (clear_cmd || pair_done);

  // History of the previous instruction
  always_ff @(posedge clk)
  begin
    if (srst)
      last_reg <= PRE_NONE;
    else if (step)
    begin
      if (pre_first)
        last_reg <= PRE_FIRST;
      else if (pre_second)
        last_reg <= PRE_SECOND;
      else
        last_reg <= PRE_NONE;
    end
  end

  // Timeout flag, a new timeout wins over a clear
  always_ff @(posedge clk)
  begin
    if (srst)
      watchdog_expiry_flag <= 1'b0;
    else if (timeout_evt)
      watchdog_expiry_flag <= 1'b1;
    else if (flag_clear || (step && halt_cmd))
      watchdog_expiry_flag <= 1'b0;
  end

  // Power-down flag
  always_ff @(posedge clk)
  begin
    if (srst)
      powerdown_flag <= 1'b0;
    else if (step && halt_cmd)
      powerdown_flag <= 1'b1;
    else if (flag_clear)
      powerdown_flag <= 1'b0;
  end

  // Watchdog counter restart pulse
  always_ff @(posedge clk)
  begin
    if (srst)
      watchdog_restart <= 1'b0;
    else
      watchdog_restart <= flag_clear || (step && halt_cmd);
  end

  // ==========================================================
  // Checks
  property p_lone_pre;
    @(posedge clk) disable iff (srst)
    (step && pre_second && last_reg != PRE_FIRST && !timeout_evt)
      |=> $stable(watchdog_expiry_flag) && $stable(powerdown_flag);
  endproperty
  a_lone_pre: assert property (p_lone_pre)
    else $error("lone pre-clear changed flags");

  property p_pair_clear;
    @(posedge clk) disable iff (srst)
    (step && pre_first) ##1 (step && pre_second && !timeout_evt)
      |=> !watchdog_expiry_flag && !powerdown_flag && watchdog_restart;
  endproperty
  a_pair_clear: assert property (p_pair_clear)
    else $error("pre-clear pair did not clear flags");

  property p_single_clear;
    @(posedge clk) disable iff (srst)
    (step && clear_cmd && !timeout_evt)
      |=> !watchdog_expiry_flag && !powerdown_flag && watchdog_restart;
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("watchdog clear did not clear flags");

  c_pair: cover property (@(posedge clk) disable iff (srst)
    (step && pre_first) ##1 (step && pre_second));

endmodule // mbe_wdt

// File: mbe_far.sv
// Data memory, program memory and stack model beside mbe_exec.
// Assumes one clock; data byte n starts as n, table word derived.
`timescale 1ns/10ps

module mbe_far
#(
  parameter int PC_W = 11
)
(
  // Clock
  input wire logic clk,
  // Data memory
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Program memory
  input wire logic prog_en,
  input wire logic [PC_W-1:0] prog_addr,
  output logic [15:0] prog_data,
  // Stack
  input wire logic push,
  input wire logic [PC_W-1:0] push_data,
  output logic [PC_W-1:0] top
);
  // ==========================================================
  // Storage
  logic [7:0] mem [256];
  logic [15:0] junk = 16'h5A5A;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0];
    top = '0;
  end
  assign rd_data = mem[rd_addr];
  // Word answered while the request stands, toggling junk otherwise
  assign prog_data = prog_en ? {prog_addr[7:0] ^ 8'hA5, prog_addr[7:0]}
                             : junk;
  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    junk <= ~junk;
    if (push)
      top <= push_data;
  end
endmodule // mbe_far

// File: testbench.sv
// Self-checking bench for mbe_exec: table rows, then hand tests.
// Assumes mbe_pkg and mbe_far are compiled first.
`timescale 1ns/10ps

module testbench;
  import mbe_pkg::*;
  // ==========================================================
  // Signals
  typedef struct {mbe_op_type o; logic [7:0] a, m, x; logic z, c; int l;}
    mbe_row_type;
  logic clk = 0, srst = 1, instr_valid = 0, timeout_evt = 0, wake = 0;
  mbe_op_type instr_op = OP_NO_OPERATION;
  logic [7:0] instr_addr = 8'h00, instr_imm = 8'h00, tbl_ptr = 8'h33;
  logic [2:0] instr_bit = 3'h0;
  logic [10:0] instr_target = 11'h040, pc, stack_top, stack_push_data;
  logic [10:0] prog_rd_addr, p;
  logic [15:0] prog_rd_data;
  logic [7:0] mem_rd_data, mem_wr_addr, mem_wr_data, table_high_latch, acc;
  logic instr_ready, mem_wr_en, prog_rd_en, stack_push, flag_c, flag_z;
  logic flag_ov, watchdog_restart;
  logic powerdown_mode, watchdog_expiry_flag, powerdown_flag;
  int errors = 0, checks_done = 0, lowc, cyc = 0;
  mbe_row_type rows [31] = '{
    '{OP_SUM_IMM, 8'h00, 8'hF0, 8'hF0, 0, 0, 0},
    '{OP_SUM_IMM, 8'h00, 8'h10, 8'h00, 1, 1, 0},
    '{OP_CONJ_IMM, 8'h00, 8'h0F, 8'h00, 1, 1, 0},
    '{OP_SUM_CARRY, 8'h05, 8'h00, 8'h06, 0, 0, 0},
    '{OP_CONJ_MEM, 8'h07, 8'h00, 8'h06, 0, 0, 0},
    '{OP_SUM_MEM, 8'h10, 8'h00, 8'h16, 0, 0, 0},
    '{OP_UNCONDITIONAL_BRANCH, 8'h00, 8'h00, 8'h16, 0, 0, 1},
    '{OP_TABLE_FETCH, 8'h20, 8'h00, 8'h16, 0, 0, 1},
    '{OP_NO_OPERATION, 8'h00, 8'h00, 8'h16, 0, 0, 0},
    '{OP_NIBBLE_EXCHANGE_TO_WORKING, 8'h12, 8'h00, 8'h21, 0, 0, 0},
    '{OP_DECREMENT_SKIP_ZERO_LOAD, 8'h01, 8'h00, 8'h00, 0, 0, 0},
    '{OP_SUM_IMM, 8'h00, 8'h55, 8'h00, 0, 0, 0},
    '{OP_SKIP_ZERO_LOAD_WORKING, 8'h03, 8'h00, 8'h03, 0, 0, 0},
    '{OP_SKIP_BIT_CLEAR, 8'h04, 8'h00, 8'h03, 0, 0, 0},
    '{OP_CONJ_IMM, 8'h00, 8'h00, 8'h03, 0, 0, 0},
    '{OP_SKIP_BIT_SET, 8'h05, 8'h00, 8'h03, 0, 0, 0},
    '{OP_SUM_IMM, 8'h00, 8'h01, 8'h03, 0, 0, 0},
    '{OP_INCREMENT_SKIP_ZERO, 8'hFF, 8'h00, 8'h03, 0, 0, 0},
    '{OP_SUM_IMM, 8'h00, 8'h01, 8'h03, 0, 0, 0},
    '{OP_DECREMENT_SKIP_ZERO, 8'h06, 8'h00, 8'h03, 0, 0, 0},
    '{OP_SUM_CARRY_TO_MEMORY, 8'h06, 8'h00, 8'h03, 0, 0, 0},
    '{OP_SUM_MEM, 8'h06, 8'h00, 8'h0B, 0, 0, 0},
    '{OP_BITWISE_CONJ_TO_MEMORY, 8'h07, 8'h00, 8'h0B, 0, 0, 0},
    '{OP_CONJ_MEM, 8'h07, 8'h00, 8'h03, 0, 0, 0},
    '{OP_MEM_SET, 8'h08, 8'h00, 8'h03, 0, 0, 0},
    '{OP_SUM_MEM, 8'h08, 8'h00, 8'h02, 0, 1, 0},
    '{OP_NIBBLE_EXCHANGE, 8'h09, 8'h00, 8'h02, 0, 1, 0},
    '{OP_SUM_CARRY, 8'h09, 8'h00, 8'h93, 0, 0, 0},
    '{OP_TABLE_FETCH_LAST_PAGE, 8'h0A, 8'h00, 8'h93, 0, 0, 1},
    '{OP_SUBROUTINE_EXIT_LOAD, 8'h00, 8'h5A, 8'h5A, 0, 0, 1},
    '{OP_INTERRUPT_EXIT, 8'h00, 8'h00, 8'h5A, 0, 0, 1}};

  mbe_exec DUT (.clk, .srst, .instr_valid, .instr_op, .instr_addr,
    .instr_imm, .instr_bit, .instr_target, .instr_ready, .pc, .mem_rd_data,
    .mem_wr_en, .mem_wr_addr, .mem_wr_data, .tbl_ptr, .prog_rd_en,
    .prog_rd_addr, .prog_rd_data, .table_high_latch, .stack_top, .stack_push,
    .stack_push_data, .stack_pop(), .interrupt_exit_pulse(), .acc, .flag_c,
    .flag_ac(), .flag_z, .flag_ov, .timeout_evt, .wake, .powerdown_mode,
    .watchdog_expiry_flag, .powerdown_flag, .watchdog_restart);
  mbe_far FAR (.clk, .rd_addr(instr_addr), .rd_data(mem_rd_data),
    .wr_en(mem_wr_en), .wr_addr(mem_wr_addr), .wr_data(mem_wr_data),
    .prog_en(prog_rd_en), .prog_addr(prog_rd_addr), .prog_data(prog_rd_data),
    .push(stack_push), .push_data(stack_push_data), .top(stack_top));

  // ==========================================================
  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      end_sim;
    end
  end

  // ==========================================================
  // Tasks
  task chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Present an op until taken, then count refused cycles; op stays up
  task run(input mbe_op_type o, input logic [7:0] a, m,
           input logic [10:0] t);
    instr_op = o;
    instr_addr = a;
    instr_imm = m;
    instr_target = t;
    instr_valid = 1'b1;
    lowc = 0;
    while (instr_ready !== 1'b1)
      @(posedge clk) #1;
    @(posedge clk) #1;
    while (instr_ready !== 1'b1 && lowc < 9)
    begin
      lowc++;
      @(posedge clk) #1;
    end
  endtask
  task idle(input int n);
    instr_valid = 1'b0;
    repeat (n) @(posedge clk) #1;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    foreach (rows[i])
    begin
      run(rows[i].o, rows[i].a, rows[i].m, 11'h040);
      chk("acc", acc, rows[i].x);
      chk("z", flag_z, rows[i].z);
      chk("c", flag_c, rows[i].c);
      chk("cycles", lowc, rows[i].l);
    end
    $display("rows done");
    chk("latch", table_high_latch, 8'h96);
    chk("table low", FAR.mem[8'h20], 8'h33);
    chk("page", prog_rd_addr, 11'h733);
    chk("last low", FAR.mem[8'h0A], 8'h33);
    run(OP_SUM_TO_MEMORY, 8'h30, 8'h00, 11'h040);
    chk("ov", flag_ov, 1'b1);
    p = pc;
    run(OP_SKIP_ON_ZERO_MEMORY, 8'h00, 8'h00, 11'h040);
    chk("mem dest", FAR.mem[8'h30], 8'h8A);
    run(OP_SUM_IMM, 8'h00, 8'h01, 11'h040);
    chk("skip acc", acc, 8'h5A);
    chk("skip pc", pc, p + 11'h002);
    p = pc;
    run(OP_SUB_CALL, 8'h00, 8'h00, 11'h123);
    chk("call cycles", lowc, 1);
    chk("pushed", stack_top, p + 11'h001);
    chk("call pc", pc, 11'h123);
    run(OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 11'h040);
    chk("exit pc", pc, p + 11'h001);
    run(OP_MEM_CLEAR, 8'h02, 8'h00, 11'h040);
    chk("pcl cycles", lowc, 1);
    chk("pcl pc", pc, (p + 11'h001) & 11'h700);
    $display("skip and call done");
    timeout_evt = 1'b1;
    idle(1);
    timeout_evt = 1'b0;
    run(OP_WATCHDOG_PRECLEAR_FIRST, 8'h00, 8'h00, 11'h040);
    run(OP_NO_OPERATION, 8'h00, 8'h00, 11'h040);
    run(OP_WATCHDOG_PRECLEAR_SECOND, 8'h00, 8'h00, 11'h040);
    chk("broken pair", watchdog_expiry_flag, 1'b1);
    run(OP_WATCHDOG_PRECLEAR_FIRST, 8'h00, 8'h00, 11'h040);
    chk("pair", watchdog_expiry_flag, 1'b0);
    run(OP_POWER_DOWN, 8'h00, 8'h00, 11'h040);
    chk("pd mode", powerdown_mode, 1'b1);
    chk("pd flag", powerdown_flag, 1'b1);
    wake = 1'b1;
    timeout_evt = 1'b1;
    idle(1);
    wake = 1'b0;
    timeout_evt = 1'b0;
    chk("woken", powerdown_mode, 1'b0);
    run(OP_WATCHDOG_CLEAR, 8'h00, 8'h00, 11'h040);
    chk("wdt to", watchdog_expiry_flag, 1'b0);
    chk("wdt pd", powerdown_flag, 1'b0);
    chk("restart", watchdog_restart, 1'b1);
    $display("watchdog done");
    srst = 1'b1;
    idle(2);
    srst = 1'b0;
    chk("reset acc", acc, 8'h00);
    chk("reset pc", pc, 11'h000);
    $display("reset done");
    end_sim;
  end
endmodule // testbench
